// [src/tss_pkg.sv]
// shared constants and types of the touch scan sequencer
package tss_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NCH      = 8;
  localparam int NSLOT    = 9;
  localparam int DW       = 16;
  localparam int AW       = 4;
  localparam int LAST_SLOT = 17;           // nine sense plus nine led slots

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [AW-1:0] A_CTRL     = 4'h0;
  localparam logic [AW-1:0] A_CHEN     = 4'h1;
  localparam logic [AW-1:0] A_THR      = 4'h2;
  localparam logic [AW-1:0] A_HYST     = 4'h3;
  localparam logic [AW-1:0] A_ACT_SKIP = 4'h4;
  localparam logic [AW-1:0] A_SLP_SKIP = 4'h5;
  localparam logic [AW-1:0] A_STATUS   = 4'h6;

  // control field positions
  localparam int C_SLEEP_EN = 0;
  localparam int C_FORCE_EN = 1;
  localparam int C_FORCE_SL = 2;
  localparam int C_PROX_EN  = 3;
  localparam int C_COMB_LO  = 8;

  // status field positions
  localparam int S_MODE = 9;
  localparam int S_IRQ  = 10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [DW-1:0] CTRL_RST     = 16'hff09;
  localparam logic [7:0]    CHEN_RST     = 8'hff;
  localparam logic [DW-1:0] THR_RST      = 16'h0100;
  localparam logic [DW-1:0] HYST_RST     = 16'h0020;
  localparam logic [7:0]    ACT_SKIP_RST = 8'h00;   // 40 ms scan
  localparam logic [7:0]    SLP_SKIP_RST = 8'h04;   // 200 ms scan

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ  = 200;
  localparam int FRAME_MS = 40;
  localparam int SLOTS    = 18;
  localparam int SLOT_CYC_DEF = FRAME_MS * 1000 * CLK_MHZ / SLOTS;

  // filter time constants as shifts
  localparam int UF_SH = 2;
  localparam int AV_SH = 4;

  typedef enum logic {TSS_ACTIVE, TSS_SLEEP} tss_mode_t;

endpackage

// [src/tss_mem_if.sv]
// filter state memory port between sequencer and store
`timescale 1ns/1ps
interface tss_mem_if #(parameter int DEPTH = 9, parameter int WW = 32);
  logic                     re;
  logic [$clog2(DEPTH)-1:0] raddr;
  logic [WW-1:0]            rdata;
  logic                     we;
  logic [$clog2(DEPTH)-1:0] waddr;
  logic [WW-1:0]            wdata;
  modport ctl (output re, raddr, we, waddr, wdata, input rdata);
  modport mem (input re, raddr, we, waddr, wdata, output rdata);
endinterface

// [src/tss_mem.sv]
// per channel filter store with registered read data
`timescale 1ns/1ps
module tss_mem #(
  parameter int DEPTH = 9,
  parameter int WW    = 32
) (
  // clock
  input wire logic ref_clk,
  // store port
  tss_mem_if.mem   mp
);
  import tss_pkg::*;

  logic [WW-1:0] mem_arr [DEPTH];
  logic [WW-1:0] rdata_reg;

  // no reset on the array: the sequencer tracks which words are valid
  always_ff @(posedge ref_clk)
  begin
    if (mp.we)
      mem_arr[mp.waddr] <= mp.wdata;
    if (mp.re)
      rdata_reg <= mem_arr[mp.raddr];
  end

  assign mp.rdata = rdata_reg;
endmodule

// [src/tss_seq.sv]
// touch scan sequencer: frame timing, modes, filtering, touch detection
// What this block does
// - frames hold nine sense slots, eight buttons and one combined proximity
// - sense slots round robin, each followed by one led drive slot
// - every slot runs full length even for disabled channels or no proximity
// - skip frames make no measurement but keep led slot timing
// - same channel repeats after one frame plus any skip frames
// - active mode scans every 40 ms by default
// - sleep mode scans every 200 ms by default
// - active and sleep scan periods are set by software
// - idle sensing frame with sleep enabled moves active mode to sleep
// - any touch or proximity in sleep returns to active mode
// - host may force the mode; forced mode overrides automatic choice
// - channel turns on when value reaches threshold plus hysteresis
// - channel turns off only below threshold minus hysteresis
// - proximity slot senses the combined electrodes in one cycle
// - interrupt raised whenever touch or release information is new
// - configuration registers may be rewritten at any time and take effect
// - short and long low pass filters; detection uses their difference
`timescale 1ns/1ps
module tss_seq
  import tss_pkg::*;
#(
  parameter int SLOT_CYC = SLOT_CYC_DEF
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst,
  // register port
  input  wire logic [tss_pkg::AW-1:0] reg_addr,
  input  wire logic [tss_pkg::DW-1:0] reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [tss_pkg::DW-1:0] reg_rdata,
  // analog sensing front end
  output logic                 meas_req,
  output logic [3:0]           meas_chan,
  output logic [7:0]           meas_comb,
  input  wire logic            meas_done,
  input  wire logic [tss_pkg::DW-1:0] meas_raw,
  // led drive and host flag
  output logic                 led_drive,
  output logic [3:0]           led_chan,
  output logic                 irq
);
  import tss_pkg::*;

  localparam int TW = $clog2(SLOT_CYC + 1);
  localparam logic [TW-1:0] TMR_LAST = TW'(SLOT_CYC - 1);

  // ****************************************
  // registers
  // ****************************************
  logic [DW-1:0]   ctrl_reg;
  logic [7:0]      chen_reg;
  logic [DW-1:0]   thr_reg;
  logic [DW-1:0]   hyst_reg;
  logic [7:0]      act_skip_reg;
  logic [7:0]      slp_skip_reg;
  logic [DW-1:0]   rdata_reg;
  logic [TW-1:0]   tmr_reg;
  logic [4:0]      slot_reg;
  logic [7:0]      skip_cnt_reg;
  logic            skip_frm_reg;
  tss_mode_t       mode_reg;
  logic            act_reg;
  logic [NSLOT-1:0] touch_reg;
  logic [NSLOT-1:0] seen_reg;
  logic            irq_reg;
  logic            meas_req_reg;
  logic [3:0]      meas_chan_reg;
  logic [7:0]      meas_comb_reg;
  logic            led_drive_reg;
  logic [3:0]      led_chan_reg;
  logic [3:0]      cur_ch_reg;
  logic [DW-1:0]   raw_reg;
  logic            upd_reg;

  // ****************************************
  // decode
  // ****************************************
  wire         slot_end   = (tmr_reg == TMR_LAST);
  wire         sense_slot = ~slot_reg[0];
  wire         frame_end  = slot_end && (slot_reg == 5'(LAST_SLOT));
  wire         start_meas = (tmr_reg == '0) && sense_slot && !skip_frm_reg;
  wire [3:0]   slot_ch    = slot_reg[4:1];
  wire         force_en   = ctrl_reg[C_FORCE_EN];
  wire         force_sl   = ctrl_reg[C_FORCE_SL];
  wire         sleep_en   = ctrl_reg[C_SLEEP_EN];
  wire [7:0]   comb_mask  = ctrl_reg[C_COMB_LO +: 8];
  wire         wr_ctrl    = reg_wr && (reg_addr == A_CTRL);
  wire         rd_status  = reg_rd && (reg_addr == A_STATUS);
  wire         det_on;                  // driven by the detector below

  // channel enable, proximity slot enabled separately
  function automatic logic ch_on(input logic [3:0] ch, input logic [7:0] en,
                                 input logic px);
    ch_on = (ch == 4'h8) ? px : en[ch[2:0]];
  endfunction

  // ****************************************
  // register port
  // ****************************************
  // any field may be rewritten at run time and is used at once
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg     <= CTRL_RST;
      chen_reg     <= CHEN_RST;
      thr_reg      <= THR_RST;
      hyst_reg     <= HYST_RST;
      act_skip_reg <= ACT_SKIP_RST;
      slp_skip_reg <= SLP_SKIP_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        A_CTRL:     ctrl_reg     <= reg_wdata;
        A_CHEN:     chen_reg     <= reg_wdata[7:0];
        A_THR:      thr_reg      <= reg_wdata;
        A_HYST:     hyst_reg     <= reg_wdata;
        A_ACT_SKIP: act_skip_reg <= reg_wdata[7:0];
        A_SLP_SKIP: slp_skip_reg <= reg_wdata[7:0];
        default:    ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  logic [DW-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    unique case (reg_addr)
      A_CTRL:     rd_mux = ctrl_reg;
      A_CHEN:     rd_mux = {8'h00, chen_reg};
      A_THR:      rd_mux = thr_reg;
      A_HYST:     rd_mux = hyst_reg;
      A_ACT_SKIP: rd_mux = {8'h00, act_skip_reg};
      A_SLP_SKIP: rd_mux = {8'h00, slp_skip_reg};
      A_STATUS:   rd_mux = {5'h00, irq_reg, mode_reg == TSS_SLEEP, touch_reg};
      default:    rd_mux = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= '0;
    else
      rdata_reg <= reg_rd ? rd_mux : '0;
  end

  // ****************************************
  // slot and frame timing
  // ****************************************
  // slots never shorten, so frame length is fixed whatever is enabled
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tmr_reg  <= '0;
      slot_reg <= '0;
    end
    else
    begin
      tmr_reg <= slot_end ? '0 : tmr_reg + 1'b1;
      if (frame_end)
        slot_reg <= '0;
      else if (slot_end)
        slot_reg <= slot_reg + 5'd1;
    end
  end

  // scan period is one frame plus the skip frames of the current mode
  wire          next_sleep;
  wire [7:0]    skip_load = next_sleep ? slp_skip_reg : act_skip_reg;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      skip_cnt_reg <= '0;
      skip_frm_reg <= 1'b0;
    end
    else if (frame_end && !skip_frm_reg)
    begin
      skip_cnt_reg <= skip_load;
      skip_frm_reg <= (skip_load != 8'h00);
    end
    else if (frame_end)
    begin
      skip_cnt_reg <= skip_cnt_reg - 8'd1;
      skip_frm_reg <= (skip_cnt_reg != 8'd1);
    end
  end

  // ****************************************
  // operating mode
  // ****************************************
  wire busy = act_reg || (|touch_reg);
  assign next_sleep = force_en ? force_sl
                    : (mode_reg == TSS_SLEEP) ? !busy
                    : (sleep_en && !busy);
  // mode moves at the end of each sensing frame; a forced mode also
  // takes hold at once so the host never waits a whole scan period
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      mode_reg <= TSS_ACTIVE;
    else if ((frame_end && !skip_frm_reg) || force_en)
      mode_reg <= next_sleep ? TSS_SLEEP : TSS_ACTIVE;
  end

  // activity seen during the current sensing frame
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      act_reg <= 1'b0;
    else if (frame_end && !skip_frm_reg)
      act_reg <= 1'b0;
    else if (upd_reg && ch_on(cur_ch_reg, chen_reg, ctrl_reg[C_PROX_EN]) && det_on)
      act_reg <= 1'b1;
  end

  // ****************************************
  // front end and led strobes
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meas_req_reg  <= 1'b0;
      meas_chan_reg <= '0;
      meas_comb_reg <= '0;
      led_drive_reg <= 1'b0;
      led_chan_reg  <= '0;
    end
    else
    begin
      meas_req_reg  <= start_meas;
      if (start_meas)
      begin
        meas_chan_reg <= slot_ch;
        meas_comb_reg <= (slot_ch == 4'h8) ? comb_mask : 8'h00;
      end
      led_drive_reg <= slot_reg[0];
      led_chan_reg  <= slot_ch;
    end
  end

  // ****************************************
  // filtering
  // ****************************************
  tss_mem_if #(.DEPTH(NSLOT), .WW(2 * DW)) mi ();

  tss_mem #(.DEPTH(NSLOT), .WW(2 * DW)) u_mem (
    .ref_clk (ref_clk),
    .mp      (mi)
  );

  // capture the result and fetch the channel's filter state
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ch_reg <= '0;
      raw_reg    <= '0;
      upd_reg    <= 1'b0;
    end
    else
    begin
      if (start_meas)
        cur_ch_reg <= slot_ch;
      if (meas_done)
        raw_reg <= meas_raw;
      upd_reg <= meas_done;
    end
  end

  wire [DW-1:0]   u_old = mi.rdata[DW-1:0];
  wire [DW-1:0]   a_old = mi.rdata[2*DW-1:DW];
  wire            seen  = seen_reg[cur_ch_reg];
  wire signed [DW:0] du = $signed({1'b0, raw_reg}) - $signed({1'b0, u_old});
  wire signed [DW:0] du_s = du >>> UF_SH;
  wire [DW-1:0]   u_new = seen ? u_old + du_s[DW-1:0] : raw_reg;
  wire signed [DW:0] da = $signed({1'b0, u_new}) - $signed({1'b0, a_old});
  wire signed [DW:0] da_s = da >>> AV_SH;
  wire [DW-1:0]   a_new = seen ? a_old + da_s[DW-1:0] : u_new;
  wire signed [DW:0] dd = $signed({1'b0, u_new}) - $signed({1'b0, a_new});
  wire [DW-1:0]   diff  = dd[DW] ? '0 : dd[DW-1:0];
  wire [DW:0]     on_lvl  = {1'b0, thr_reg} + {1'b0, hyst_reg};
  wire [DW-1:0]   off_lvl = (thr_reg < hyst_reg) ? '0 : thr_reg - hyst_reg;
  assign det_on = ({1'b0, diff} >= on_lvl);
  wire            det_off = (diff < off_lvl);

  assign mi.re    = meas_done;
  assign mi.raddr = cur_ch_reg;
  assign mi.we    = upd_reg;
  assign mi.waddr = cur_ch_reg;
  assign mi.wdata = {a_new, u_new};

  // ****************************************
  // touch state and host flag
  // ****************************************
  wire ch_en = ch_on(cur_ch_reg, chen_reg, ctrl_reg[C_PROX_EN]);
  wire cur_t = touch_reg[cur_ch_reg];
  wire new_t = cur_t ? !det_off : det_on;
  wire chg   = upd_reg && ch_en && (new_t != cur_t);

  // disabled channels keep both their state and the flag quiet
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      touch_reg <= '0;
      seen_reg  <= '0;
    end
    else if (upd_reg)
    begin
      seen_reg[cur_ch_reg] <= 1'b1;
      if (ch_en)
        touch_reg[cur_ch_reg] <= new_t;
    end
  end

  // new information wins over a status read in the same cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else if (chg)
      irq_reg <= 1'b1;
    else if (rd_status)
      irq_reg <= 1'b0;
  end

  assign reg_rdata = rdata_reg;
  assign meas_req  = meas_req_reg;
  assign meas_chan = meas_chan_reg;
  assign meas_comb = meas_comb_reg;
  assign led_drive = led_drive_reg;
  assign led_chan  = led_chan_reg;
  assign irq       = irq_reg;

  // ****************************************
  // checks
  // ****************************************
  a_frame_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    frame_end |=> slot_reg == 5'd0)
    else $error("frame did not wrap after slot 17");

  a_led_follow: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(slot_reg[0]) |=> led_drive_reg && (led_chan_reg == $past(slot_ch)))
    else $error("led slot not driven after sense slot");

  a_slot_len: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(slot_reg) |-> $past(tmr_reg) == TMR_LAST)
    else $error("slot ended early");

  a_skip_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    skip_frm_reg && $past(skip_frm_reg) |-> !meas_req_reg)
    else $error("measurement in skip frame");

  a_meas_start: assert property (@(posedge ref_clk) disable iff (rst)
    start_meas |=> meas_req_reg ##1 !meas_req_reg)
    else $error("measurement request not one cycle");

  a_comb_mask: assert property (@(posedge ref_clk) disable iff (rst)
    meas_req_reg && meas_chan_reg == 4'h8 |-> meas_comb_reg == $past(comb_mask))
    else $error("combined mask wrong in proximity slot");

  a_force_mode: assert property (@(posedge ref_clk) disable iff (rst)
    force_en |=> mode_reg == ($past(force_sl) ? TSS_SLEEP : TSS_ACTIVE))
    else $error("forced mode not followed");

  a_auto_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    frame_end && !skip_frm_reg && !force_en && sleep_en && !busy |=> mode_reg == TSS_SLEEP)
    else $error("idle frame did not enter sleep");

  a_wake_touch: assert property (@(posedge ref_clk) disable iff (rst)
    frame_end && !skip_frm_reg && !force_en && (|touch_reg) |=> mode_reg == TSS_ACTIVE)
    else $error("touch did not wake");

  a_touch_on: assert property (@(posedge ref_clk) disable iff (rst)
    upd_reg && ch_en && !cur_t && det_on |=> touch_reg[$past(cur_ch_reg)])
    else $error("touch not detected");

  a_touch_hold: assert property (@(posedge ref_clk) disable iff (rst)
    upd_reg && ch_en && cur_t && !det_off |=> touch_reg[$past(cur_ch_reg)])
    else $error("released inside hysteresis band");

  a_dis_keep: assert property (@(posedge ref_clk) disable iff (rst)
    upd_reg && !ch_en |=> $stable(touch_reg) && !$rose(irq_reg))
    else $error("disabled channel changed state");

  a_irq_set: assert property (@(posedge ref_clk) disable iff (rst)
    chg |=> irq_reg)
    else $error("no interrupt on touch change");
endmodule

// [verification/tss_fe_model.sv]
// behavioural front end: answers each measurement request with a raw value
`timescale 1ns/1ps
module tss_fe_model (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // request side
  input  wire logic                          meas_req,
  input  wire logic [3:0]                    meas_chan,
  input  wire logic [7:0]                    meas_comb,
  // stimulus from the bench
  input  wire logic [8:0][tss_pkg::DW-1:0]   level,
  input  wire logic [3:0]                    lat,
  // answer
  output logic                               meas_done,
  output logic [tss_pkg::DW-1:0]             meas_raw
);
  import tss_pkg::*;
  logic [3:0]    chan_reg;
  logic [3:0]    cnt_reg;
  logic          busy_reg;
  logic [DW-1:0] last_reg;
  logic [DW-1:0] raw_w;

  // the combined slot only has charge when some electrodes are tied together
  assign raw_w = (chan_reg == 4'h8 && meas_comb == 8'h00) ? 16'h0000 : level[chan_reg];

  // one answer per request after a bench chosen delay; idle data is never stale
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_reg  <= 1'b0;
      cnt_reg   <= 4'h0;
      chan_reg  <= 4'h0;
      meas_done <= 1'b0;
      last_reg  <= 16'h0000;
      meas_raw  <= 16'h5a5a;
    end
    else
    begin
      meas_done <= 1'b0;
      meas_raw  <= ~last_reg;
      if (meas_req)
      begin
        busy_reg <= 1'b1;
        cnt_reg  <= lat;
        chan_reg <= meas_chan;
      end
      else if (busy_reg && cnt_reg == 4'h0)
      begin
        busy_reg  <= 1'b0;
        meas_done <= 1'b1;
        meas_raw  <= raw_w;
        last_reg  <= raw_w;
      end
      else if (busy_reg)
        cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule

// [verification/tss_seq_tb_top.sv]
// self-checking bench for the touch scan sequencer
`timescale 1ns/1ps
module tss_seq_tb_top;
  import tss_pkg::*;
  localparam int SC = 20;
  localparam int FR = 18 * SC;
  logic               ref_clk;
  logic               rst;
  logic [AW-1:0]      reg_addr;
  logic [DW-1:0]      reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [DW-1:0]      reg_rdata;
  logic               meas_req;
  logic [3:0]         meas_chan;
  logic [7:0]         meas_comb;
  logic               meas_done;
  logic [DW-1:0]      meas_raw;
  logic               led_drive;
  logic [3:0]         led_chan;
  logic               irq;
  logic [8:0][DW-1:0] level;
  logic [3:0]         lat;
  logic [DW-1:0]      base [9];
  logic [DW-1:0]      exp_q [$];
  logic               rd_d;
  logic [3:0]         prev_ch;
  logic [8:0]         touch_exp;
  logic               irq_exp;
  logic               mode_exp;
  logic [7:0]         chen_exp;
  logic [7:0]         comb_exp;
  logic               prox_exp;
  logic [31:0]        rnd_st;
  int                 error_cnt;
  int                 comparisons;
  int                 cyc;
  int                 since;
  int                 gap_c0;
  int                 n_req;
  int                 thr_exp;
  int                 hyst_exp;
  int                 useful [9];
  int                 avg [9];
  bit                 seen [9];

  tss_seq #(.SLOT_CYC(SC)) tss_seq_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas_req(meas_req), .meas_chan(meas_chan), .meas_comb(meas_comb),
    .meas_done(meas_done), .meas_raw(meas_raw), .led_drive(led_drive),
    .led_chan(led_chan), .irq(irq));
  tss_fe_model tss_fe_model_i (.ref_clk(ref_clk), .rst(rst), .meas_req(meas_req),
    .meas_chan(meas_chan), .meas_comb(meas_comb), .level(level), .lat(lat),
    .meas_done(meas_done), .meas_raw(meas_raw));

  // ****************************************
  // helpers
  // ****************************************
  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk_v(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reference filter and detector; a disabled channel still filters
  task automatic filt(input int ch, input int raw);
    int d;
    if (!seen[ch])
    begin
      useful[ch] = raw;
      avg[ch] = raw;
      seen[ch] = 1'b1;
    end
    else
    begin
      useful[ch] = useful[ch] + ((raw - useful[ch]) >>> 2);
      avg[ch] = avg[ch] + ((useful[ch] - avg[ch]) >>> 4);
    end
    d = (useful[ch] > avg[ch]) ? useful[ch] - avg[ch] : 0;
    if ((ch < 8 && !chen_exp[ch]) || (ch == 8 && !prox_exp))
      return;
    if (!touch_exp[ch] && d >= thr_exp + hyst_exp)
    begin
      touch_exp[ch] = 1'b1;
      irq_exp = 1'b1;
    end
    else if (touch_exp[ch] && d < thr_exp - hyst_exp)
    begin
      touch_exp[ch] = 1'b0;
      irq_exp = 1'b1;
    end
  endtask

  // ****************************************
  // register bus and waits
  // ****************************************
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic wait_ch(input int c, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      while (!(meas_req === 1'b1 && meas_chan === 4'(c)))
        @(posedge ref_clk);
    end
    @(negedge ref_clk); // let the monitor log the gap first
  endtask

  // status read at a quiet point of the frame; the read clears the flag
  task automatic st_chk;
    wait_ch(1, 1);
    chk_v(16'(irq), 16'(irq_exp), "irq level");
    rd(A_STATUS, {5'h00, irq_exp, mode_exp, touch_exp});
    irq_exp = 1'b0;
  endtask

  // ****************************************
  // monitor: read data, slot order, led slots, timeout
  // ****************************************
  always @(posedge ref_clk)
  begin
    cyc++;
    if (rd_d)
      chk_v(reg_rdata, exp_q.pop_front(), "read data");
    else if (!rst)
      chk_v(reg_rdata, 16'h0000, "idle read data");
    rd_d <= reg_rd;
    since++;
    if (!rst && meas_done)
      filt(int'(prev_ch), int'(meas_raw));
    if (!rst && meas_req)
    begin
      if (n_req == 0)
        chk_v(16'(meas_chan), 16'h0000, "first channel");
      else if (meas_chan == 4'h0)
      begin
        chk_v(16'(prev_ch), 16'h0008, "frame length");
        gap_c0 = since;
        chk_n((since - 2 * SC) % FR, 0, "skip spacing");
      end
      else
      begin
        chk_v(16'(meas_chan), 16'(prev_ch) + 16'h0001, "channel order");
        chk_n(since, 2 * SC, "slot spacing");
      end
      chk_v(16'(meas_comb), (meas_chan == 4'h8) ? 16'(comb_exp) : 16'h0000, "comb");
      prev_ch = meas_chan;
      n_req++;
      since = 0;
      rnd_st = xs(rnd_st);
      lat <= 4'h6 + {1'b0, rnd_st[2:0]};
    end
    if (n_req > 0 && since == SC / 2)
      chk_v(16'(led_drive), 16'h0000, "sense slot led");
    if (n_req > 0 && since == SC + SC / 2)
      chk_v({11'h000, led_drive, led_chan}, {11'h000, 1'b1, prev_ch}, "led slot");
    // ceiling well above the roughly 17350 cycles the sequence needs
    if (cyc == 80000)
    begin
      error_cnt++;
      final_report;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [DW-1:0] rv [8];
    rv = '{CTRL_RST, 16'(CHEN_RST), THR_RST, HYST_RST, 16'(ACT_SKIP_RST),
           16'(SLP_SKIP_RST), 16'h0000, 16'h0000};
    ref_clk = 1'b0;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    lat = 4'h8;
    rnd_st = 32'h875456fa;
    touch_exp = 9'h000;
    irq_exp = 1'b0;
    mode_exp = 1'b0;
    chen_exp = 8'hff;
    comb_exp = 8'hff;
    prox_exp = 1'b1;
    thr_exp = 256;
    hyst_exp = 32;
    for (int i = 0; i < 9; i++)
    begin
      rnd_st = xs(rnd_st);
      base[i] = 16'h0400 + {8'h00, rnd_st[7:0]};
      level[i] = base[i];
    end
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, a read-only and an unmapped place
    foreach (rv[i]) rd(4'(i), rv[i]);
    wr(A_STATUS, 16'hffff);
    wr(4'hf, 16'h1234);
    rd(A_STATUS, 16'h0000);
    rd(4'hf, 16'h0000);
    // forced active mode and new detection levels
    wr(A_CTRL, 16'hff0b);
    wr(A_THR, 16'h0010);
    wr(A_HYST, 16'h0008);
    thr_exp = 16;
    hyst_exp = 8;
    wait_ch(0, 2);
    st_chk;
    wr(A_CHEN, 16'h00df);
    chen_exp = 8'hdf;
    level[3] <= base[3] + 16'h0200;
    level[5] <= base[5] + 16'h0200;
    repeat (8) st_chk;
    level[3] <= base[3];
    repeat (4) st_chk;
    // skip frames in active mode, then back to the short period
    wr(A_ACT_SKIP, 16'h0002);
    wait_ch(0, 3);
    chk_n(gap_c0, 2 * SC + 2 * FR, "active skip period");
    wr(A_ACT_SKIP, 16'h0000);
    wait_ch(0, 3);
    chk_n(gap_c0, 2 * SC, "active period");
    // automatic sleep when idle, wake on touch
    wr(A_CTRL, 16'hff09);
    mode_exp = 1'b1;
    wait_ch(0, 3);
    chk_n(gap_c0, 2 * SC + 4 * FR, "sleep period");
    st_chk;
    level[2] <= base[2] + 16'h0200;
    mode_exp = 1'b0;
    wait_ch(0, 2);
    st_chk;
    // forced sleep wins over a held touch; proximity off, narrower mask
    wr(A_CTRL, 16'h3307);
    comb_exp = 8'h33;
    prox_exp = 1'b0;
    mode_exp = 1'b1;
    st_chk;
    final_report;
  end
endmodule
